// [hw/rsx_pkg.sv]
/*
  Package for the rotate, subtract, skip, table-read and exclusive-OR
  execution block: APB carriers, register offsets, field positions,
  reset values, operation codes and controller states.
  Assumes a 32-bit APB with byte addresses and one clock at 125 MHz.
*/
package rsx_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rsx_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rsx_apb_rsp_t;

  localparam int PM_AW = 12;
  localparam int PM_DW = 16;
  localparam logic [3:0] LAST_PAGE = 4'hF;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_MEM = 8'h08;
  localparam logic [7:0] OFS_IMM = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_TPTR_LO = 8'h14;
  localparam logic [7:0] OFS_TPTR_HI = 8'h18;
  localparam logic [7:0] OFS_TLATCH = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BIT_LSB = 5;
  localparam int CTRL_HIPTR_POS = 8;
  localparam int CTRL_GO_POS = 9;
  localparam int FLG_CY_POS = 0;
  localparam int FLG_HALF_POS = 1;
  localparam int FLG_Z_POS = 2;
  localparam int FLG_RANGE_POS = 3;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_SKIP_POS = 1;
  localparam int ST_BADOP_POS = 2;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;

  typedef enum logic [4:0] {
    rotate_left_to_acc, rotate_left_thru_cy_mem, rotate_left_thru_cy_to_acc,
    rotate_right_mem, rotate_right_to_acc, rotate_right_via_cy_mem,
    rotate_right_via_cy_to_acc, subtract_borrow_to_acc, subtract_borrow_to_mem,
    subtract_to_acc, subtract_imm_to_acc, subtract_to_mem,
    decrement_skip_zero_mem, decrement_skip_zero_to_acc,
    increment_skip_zero_mem, increment_skip_zero_to_acc,
    skip_bit_set, skip_bit_clear, skip_if_zero_mem, copy_skip_if_zero,
    set_all_mem, set_bit_mem, nibble_exchange_mem, nibble_exchange_to_acc,
    program_word_read, last_page_word_read, exclusive_or_to_acc,
    exclusive_or_imm_to_acc, exclusive_or_to_mem, op_none_29, op_none_30, op_none_31
  } rsx_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY, ST_TWAIT} rsx_state_t;
endpackage

// [hw/rsx_exec.sv]
/*
  Execution block for rotates, subtractions, skips, set, nibble exchange,
  table reads and exclusive-OR on an 8-bit accumulator and operand byte.
  Assumes an APB master on pclk and a program memory that returns the
  word for pm_addr combinationally while pm_rd is high.
*/
`timescale 1ns/1ps
`default_nettype none
module rsx_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire rsx_pkg::rsx_apb_req_t apb_req,
  output rsx_pkg::rsx_apb_rsp_t apb_rsp,
  output logic pm_rd,
  output logic [rsx_pkg::PM_AW-1:0] pm_addr,
  input wire logic [rsx_pkg::PM_DW-1:0] pm_rdata,
  output logic skip_pulse
);
  typedef struct packed {
    rsx_pkg::rsx_state_t st;
    rsx_pkg::rsx_op_t op;
    logic [2:0] bidx;
    logic use_hi;
    logic [7:0] acc;
    logic [7:0] mem;
    logic [7:0] imm;
    logic [7:0] tlo;
    logic [7:0] thi;
    logic [7:0] tlatch;
    logic cy;
    logic half;
    logic z;
    logic range;
    logic skip;
    logic bad_op;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pm_rd;
    logic [rsx_pkg::PM_AW-1:0] pm_addr;
    logic skip_o;
  } rsx_regs_t;

  rsx_regs_t r;
  rsx_regs_t n;

  // Subtractor shared by all subtract operations
  logic [7:0] sub_b;
  logic sub_bin;
  logic [8:0] sub_full;
  logic [4:0] sub_low;
  logic [7:0] sub_res;
  logic sub_ovf;
  logic [7:0] bit_mask;
  logic [7:0] dec_v;
  logic [7:0] inc_v;
  logic [7:0] swp_v;
  logic setup;
  logic wr_take;
  logic mapped;
  logic [31:0] rd_val;

  always_comb begin
    sub_b = (r.op == rsx_pkg::subtract_imm_to_acc) ? r.imm : r.mem;
    sub_bin = (r.op == rsx_pkg::subtract_borrow_to_acc ||
               r.op == rsx_pkg::subtract_borrow_to_mem) ? ~r.cy : 1'b0;
    sub_full = {1'b0, r.acc} - {1'b0, sub_b} - {8'h00, sub_bin};
    sub_low = {1'b0, r.acc[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, sub_bin};
    sub_res = sub_full[7:0];
    sub_ovf = (r.acc[7] != sub_b[7]) && (sub_res[7] != r.acc[7]);
    bit_mask = 8'h01 << r.bidx;
    dec_v = r.mem - 8'h01;
    inc_v = r.mem + 8'h01;
    swp_v = {r.mem[3:0], r.mem[7:4]};
  end

  // Register read decode
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    if (apb_req.paddr == rsx_pkg::OFS_CTRL) begin
      rd_val[rsx_pkg::CTRL_OP_LSB +: 5] = r.op;
      rd_val[rsx_pkg::CTRL_BIT_LSB +: 3] = r.bidx;
      rd_val[rsx_pkg::CTRL_HIPTR_POS] = r.use_hi;
    end else if (apb_req.paddr == rsx_pkg::OFS_ACC) begin
      rd_val[7:0] = r.acc;
    end else if (apb_req.paddr == rsx_pkg::OFS_MEM) begin
      rd_val[7:0] = r.mem;
    end else if (apb_req.paddr == rsx_pkg::OFS_IMM) begin
      rd_val[7:0] = r.imm;
    end else if (apb_req.paddr == rsx_pkg::OFS_FLAGS) begin
      rd_val[rsx_pkg::FLG_CY_POS] = r.cy;
      rd_val[rsx_pkg::FLG_HALF_POS] = r.half;
      rd_val[rsx_pkg::FLG_Z_POS] = r.z;
      rd_val[rsx_pkg::FLG_RANGE_POS] = r.range;
    end else if (apb_req.paddr == rsx_pkg::OFS_TPTR_LO) begin
      rd_val[7:0] = r.tlo;
    end else if (apb_req.paddr == rsx_pkg::OFS_TPTR_HI) begin
      rd_val[7:0] = r.thi;
    end else if (apb_req.paddr == rsx_pkg::OFS_TLATCH) begin
      rd_val[7:0] = r.tlatch;
    end else if (apb_req.paddr == rsx_pkg::OFS_STATUS) begin
      rd_val[rsx_pkg::ST_BUSY_POS] = (r.st != rsx_pkg::ST_IDLE);
      rd_val[rsx_pkg::ST_SKIP_POS] = r.skip;
      rd_val[rsx_pkg::ST_BADOP_POS] = r.bad_op;
    end else begin
      mapped = 1'b0;
    end
  end

  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_take = apb_req.psel && apb_req.penable && r.pready && apb_req.pwrite &&
                   !r.pslverr;

  always_comb begin
    n = r;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.pm_rd = 1'b0;
    n.skip_o = 1'b0;

    // Zero-wait APB: answer prepared in the setup cycle
    if (setup) begin
      n.pready = 1'b1;
      n.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_val;
      n.pslverr = !mapped || (apb_req.pwrite && r.st != rsx_pkg::ST_IDLE) ||
                  (apb_req.pwrite && apb_req.paddr == rsx_pkg::OFS_TLATCH) ||
                  (apb_req.pwrite && apb_req.paddr == rsx_pkg::OFS_STATUS);
    end

    if (wr_take) begin
      if (apb_req.paddr == rsx_pkg::OFS_CTRL) begin
        n.op = rsx_pkg::rsx_op_t'(apb_req.pwdata[rsx_pkg::CTRL_OP_LSB +: 5]);
        n.bidx = apb_req.pwdata[rsx_pkg::CTRL_BIT_LSB +: 3];
        n.use_hi = apb_req.pwdata[rsx_pkg::CTRL_HIPTR_POS];
        if (apb_req.pwdata[rsx_pkg::CTRL_GO_POS]) begin
          n.st = rsx_pkg::ST_EXEC;
          n.skip = 1'b0;
          n.bad_op = 1'b0;
        end
      end else if (apb_req.paddr == rsx_pkg::OFS_ACC) begin
        n.acc = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == rsx_pkg::OFS_MEM) begin
        n.mem = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == rsx_pkg::OFS_IMM) begin
        n.imm = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == rsx_pkg::OFS_FLAGS) begin
        n.cy = apb_req.pwdata[rsx_pkg::FLG_CY_POS];
        n.half = apb_req.pwdata[rsx_pkg::FLG_HALF_POS];
        n.z = apb_req.pwdata[rsx_pkg::FLG_Z_POS];
        n.range = apb_req.pwdata[rsx_pkg::FLG_RANGE_POS];
      end else if (apb_req.paddr == rsx_pkg::OFS_TPTR_LO) begin
        n.tlo = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == rsx_pkg::OFS_TPTR_HI) begin
        n.thi = apb_req.pwdata[7:0];
      end
    end

    case (r.st)
      rsx_pkg::ST_EXEC: begin
        n.st = rsx_pkg::ST_IDLE;
        case (r.op)
          rsx_pkg::rotate_left_to_acc: n.acc = {r.mem[6:0], r.mem[7]};
          rsx_pkg::rotate_left_thru_cy_mem: begin
            n.mem = {r.mem[6:0], r.cy};
            n.cy = r.mem[7];
          end
          rsx_pkg::rotate_left_thru_cy_to_acc: begin
            n.acc = {r.mem[6:0], r.cy};
            n.cy = r.mem[7];
          end
          rsx_pkg::rotate_right_mem: n.mem = {r.mem[0], r.mem[7:1]};
          rsx_pkg::rotate_right_to_acc: n.acc = {r.mem[0], r.mem[7:1]};
          rsx_pkg::rotate_right_via_cy_mem: begin
            n.mem = {r.cy, r.mem[7:1]};
            n.cy = r.mem[0];
          end
          rsx_pkg::rotate_right_via_cy_to_acc: begin
            n.acc = {r.cy, r.mem[7:1]};
            n.cy = r.mem[0];
          end
          rsx_pkg::subtract_borrow_to_acc, rsx_pkg::subtract_borrow_to_mem,
          rsx_pkg::subtract_to_acc, rsx_pkg::subtract_imm_to_acc,
          rsx_pkg::subtract_to_mem: begin
            if (r.op == rsx_pkg::subtract_borrow_to_mem ||
                r.op == rsx_pkg::subtract_to_mem) begin
              n.mem = sub_res;
            end else begin
              n.acc = sub_res;
            end
            n.cy = ~sub_full[8];
            n.half = ~sub_low[4];
            n.range = sub_ovf;
            n.z = (sub_res == 8'h00);
          end
          rsx_pkg::decrement_skip_zero_mem, rsx_pkg::decrement_skip_zero_to_acc: begin
            if (r.op == rsx_pkg::decrement_skip_zero_mem) n.mem = dec_v;
            else n.acc = dec_v;
            n.skip = (dec_v == 8'h00);
            n.st = rsx_pkg::ST_DUMMY;
          end
          rsx_pkg::increment_skip_zero_mem, rsx_pkg::increment_skip_zero_to_acc: begin
            if (r.op == rsx_pkg::increment_skip_zero_mem) n.mem = inc_v;
            else n.acc = inc_v;
            n.skip = (inc_v == 8'h00);
            n.st = rsx_pkg::ST_DUMMY;
          end
          rsx_pkg::skip_bit_set: begin
            n.skip = |(r.mem & bit_mask);
            n.st = rsx_pkg::ST_DUMMY;
          end
          rsx_pkg::skip_bit_clear: begin
            n.skip = ~|(r.mem & bit_mask);
            n.st = rsx_pkg::ST_DUMMY;
          end
          rsx_pkg::skip_if_zero_mem: begin
            n.mem = r.mem;
            n.skip = (r.mem == 8'h00);
            n.st = rsx_pkg::ST_DUMMY;
          end
          rsx_pkg::copy_skip_if_zero: begin
            n.acc = r.mem;
            n.skip = (r.mem == 8'h00);
            n.st = rsx_pkg::ST_DUMMY;
          end
          rsx_pkg::set_all_mem: n.mem = rsx_pkg::ALL_ONES;
          rsx_pkg::set_bit_mem: n.mem = r.mem | bit_mask;
          rsx_pkg::nibble_exchange_mem: n.mem = swp_v;
          rsx_pkg::nibble_exchange_to_acc: n.acc = swp_v;
          rsx_pkg::program_word_read: begin
            n.pm_rd = 1'b1;
            n.pm_addr = r.use_hi ? {r.thi[3:0], r.tlo} : {4'h0, r.tlo};
            n.st = rsx_pkg::ST_TWAIT;
          end
          rsx_pkg::last_page_word_read: begin
            n.pm_rd = 1'b1;
            n.pm_addr = {rsx_pkg::LAST_PAGE, r.tlo};
            n.st = rsx_pkg::ST_TWAIT;
          end
          rsx_pkg::exclusive_or_to_acc, rsx_pkg::exclusive_or_imm_to_acc: begin
            n.acc = r.acc ^ ((r.op == rsx_pkg::exclusive_or_imm_to_acc) ? r.imm : r.mem);
            n.z = (n.acc == 8'h00);
          end
          rsx_pkg::exclusive_or_to_mem: begin
            n.mem = r.acc ^ r.mem;
            n.z = ((r.acc ^ r.mem) == 8'h00);
          end
          default: n.bad_op = 1'b1;
        endcase
      end
      rsx_pkg::ST_DUMMY: begin
        // Dummy cycle while the next instruction would be fetched
        n.skip_o = r.skip;
        n.st = rsx_pkg::ST_IDLE;
      end
      rsx_pkg::ST_TWAIT: begin
        n.mem = pm_rdata[7:0];
        n.tlatch = pm_rdata[15:8];
        n.st = rsx_pkg::ST_IDLE;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign apb_rsp.prdata = r.prdata;
  assign apb_rsp.pready = r.pready;
  assign apb_rsp.pslverr = r.pslverr;
  assign pm_rd = r.pm_rd;
  assign pm_addr = r.pm_addr;
  assign skip_pulse = r.skip_o;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rl_acc_a: assert property (
    r.st == rsx_pkg::ST_EXEC && r.op == rsx_pkg::rotate_left_to_acc |=>
      r.acc == {$past(r.mem[6:0]), $past(r.mem[7])} && $stable(r.mem) && $stable(r.cy))
    else $error("rotate left to acc wrong");
  rlc_mem_a: assert property (
    r.st == rsx_pkg::ST_EXEC && r.op == rsx_pkg::rotate_left_thru_cy_mem |=>
      r.mem == {$past(r.mem[6:0]), $past(r.cy)} && r.cy == $past(r.mem[7]))
    else $error("rotate through carry wrong");
  rrc_acc_a: assert property (
    r.st == rsx_pkg::ST_EXEC && r.op == rsx_pkg::rotate_right_via_cy_to_acc |=>
      r.acc == {$past(r.cy), $past(r.mem[7:1])} && r.cy == $past(r.mem[0]) &&
      $stable(r.mem))
    else $error("rotate right via carry wrong");
  sub_carry_a: assert property (
    r.st == rsx_pkg::ST_EXEC && r.op == rsx_pkg::subtract_to_acc |=>
      r.cy == ($past(r.acc) >= $past(r.mem)) && r.acc == $past(r.acc) - $past(r.mem))
    else $error("subtract carry wrong");
  sbc_borrow_a: assert property (
    r.st == rsx_pkg::ST_EXEC && r.op == rsx_pkg::subtract_borrow_to_mem && !r.cy |=>
      r.mem == $past(r.acc) - $past(r.mem) - 8'h01 && $stable(r.acc))
    else $error("subtract with borrow wrong");
  skip_two_a: assert property (
    r.st == rsx_pkg::ST_EXEC && r.op == rsx_pkg::skip_bit_set |=>
      r.st == rsx_pkg::ST_DUMMY ##1 r.st == rsx_pkg::ST_IDLE && skip_pulse == r.skip)
    else $error("skip not two cycles");
  dec_skip_a: assert property (
    r.st == rsx_pkg::ST_EXEC && r.op == rsx_pkg::decrement_skip_zero_mem &&
    r.mem == 8'h01 |=> ##1 skip_pulse && r.mem == 8'h00)
    else $error("decrement skip missed");
  bit_clr_a: assert property (
    r.st == rsx_pkg::ST_EXEC && r.op == rsx_pkg::skip_bit_clear |=>
      r.skip == !$past(r.mem[r.bidx]) && $stable(r.mem) && $stable(r.z))
    else $error("bit clear test wrong");
  tbl_last_a: assert property (
    r.st == rsx_pkg::ST_EXEC && r.op == rsx_pkg::last_page_word_read |=>
      pm_rd && pm_addr == {rsx_pkg::LAST_PAGE, $past(r.tlo)} ##1
      r.tlatch == $past(pm_rdata[15:8]) && r.mem == $past(pm_rdata[7:0]))
    else $error("last page read wrong");
  xor_flag_a: assert property (
    r.st == rsx_pkg::ST_EXEC && r.op == rsx_pkg::exclusive_or_to_mem |=>
      r.mem == ($past(r.acc) ^ $past(r.mem)) && r.z == (r.mem == 8'h00) && $stable(r.cy))
    else $error("exclusive or wrong");
endmodule // rsx_exec
`default_nettype wire

// [verification/rsx_pm_model.sv]
/*
  Program memory stand-in for the execution block.
  Assumes pm_addr is valid while pm_rd is high; answers in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rsx_pm_model (
  input wire logic pclk,
  input wire logic pm_rd,
  input wire logic [rsx_pkg::PM_AW-1:0] pm_addr,
  output logic [rsx_pkg::PM_DW-1:0] pm_rdata
);
  logic [rsx_pkg::PM_DW-1:0] idle_r = 16'h5A5A;
  // Outside a read the word toggles so that stale data cannot pass
  always @(posedge pclk) begin
    idle_r <= ~idle_r;
  end
  // High byte holds page and low nibble, low byte a scrambled address
  assign pm_rdata = pm_rd ? {pm_addr[11:8], pm_addr[3:0], pm_addr[7:0] ^ 8'hA5} : idle_r;
endmodule // rsx_pm_model
`default_nettype wire

// [verification/rsx_exec_test.sv]
/*
  Self-checking bench for the execution block: APB tasks, a reference
  model of each operation and table reads against the memory stand-in.
  Assumes the zero-wait APB slave and register map of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module rsx_exec_test;
  logic pclk;
  logic presetn;
  rsx_pkg::rsx_apb_req_t apb_req;
  rsx_pkg::rsx_apb_rsp_t apb_rsp;
  logic pm_rd;
  logic [rsx_pkg::PM_AW-1:0] pm_addr;
  logic [rsx_pkg::PM_AW-1:0] read_addr;
  logic [rsx_pkg::PM_DW-1:0] pm_rdata;
  logic skip_pulse;
  logic [31:0] rd;
  logic er;
  int bad_count;
  int checked;
  int cyc;
  int pulses;
  int pulse_cyc;
  int go_cyc;
  int op_cyc;

  rsx_exec u_rsx_exec (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .skip_pulse(skip_pulse));
  rsx_pm_model u_rsx_pm_model (.pclk(pclk), .pm_rd(pm_rd), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  always @(negedge pclk) begin
    if (skip_pulse === 1'b1) begin
      pulses = pulses + 1;
      pulse_cyc = cyc;
    end
    if (pm_rd === 1'b1) read_addr = pm_addr;
  end

  task automatic close_out();
    $display("Counts: %0d compared, %0d wrong", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Setup cycle, then access held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (apb_rsp.pready !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: no bus answer", $time);
      close_out();
    end
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    go_cyc = cyc;
    apb_req <= '0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask

  task automatic run(input logic [4:0] op, input logic [2:0] bi, input logic hp);
    int n;
    n = 0;
    xfer(1'b1, rsx_pkg::OFS_CTRL, {22'h0, 1'b1, hp, bi, op});
    op_cyc = go_cyc;
    do begin
      xfer(1'b0, rsx_pkg::OFS_STATUS, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    chk({31'h0, rd[0]}, 32'h0000_0000, "busy cleared");
  endtask

  function automatic void model(input rsx_pkg::rsx_op_t op, input logic [2:0] bi,
      input logic [7:0] a, m, x, input logic [3:0] f,
      output logic [7:0] na, nm, output logic [3:0] nf, output logic sk);
    logic [7:0] s;
    logic bin;
    logic [8:0] d;
    logic [4:0] h;
    na = a;
    nm = m;
    nf = f;
    s = (op == rsx_pkg::subtract_imm_to_acc || op == rsx_pkg::exclusive_or_imm_to_acc) ? x : m;
    bin = (op == rsx_pkg::subtract_borrow_to_acc || op == rsx_pkg::subtract_borrow_to_mem)
      ? ~f[0] : 1'b0;
    d = {1'b0, a} - {1'b0, s} - {8'h00, bin};
    h = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, bin};
    case (op)
      rsx_pkg::rotate_left_to_acc: na = {m[6:0], m[7]};
      rsx_pkg::rotate_left_thru_cy_mem: {nm, nf[0]} = {m[6:0], f[0], m[7]};
      rsx_pkg::rotate_left_thru_cy_to_acc: {na, nf[0]} = {m[6:0], f[0], m[7]};
      rsx_pkg::rotate_right_mem: nm = {m[0], m[7:1]};
      rsx_pkg::rotate_right_to_acc: na = {m[0], m[7:1]};
      rsx_pkg::rotate_right_via_cy_mem: {nm, nf[0]} = {f[0], m};
      rsx_pkg::rotate_right_via_cy_to_acc: {na, nf[0]} = {f[0], m};
      rsx_pkg::subtract_borrow_to_acc, rsx_pkg::subtract_to_acc,
      rsx_pkg::subtract_imm_to_acc: na = d[7:0];
      rsx_pkg::subtract_borrow_to_mem, rsx_pkg::subtract_to_mem: nm = d[7:0];
      rsx_pkg::decrement_skip_zero_mem: nm = m - 8'h01;
      rsx_pkg::decrement_skip_zero_to_acc: na = m - 8'h01;
      rsx_pkg::increment_skip_zero_mem: nm = m + 8'h01;
      rsx_pkg::increment_skip_zero_to_acc: na = m + 8'h01;
      rsx_pkg::copy_skip_if_zero: na = m;
      rsx_pkg::set_all_mem: nm = rsx_pkg::ALL_ONES;
      rsx_pkg::set_bit_mem: nm[bi] = 1'b1;
      rsx_pkg::nibble_exchange_mem: nm = {m[3:0], m[7:4]};
      rsx_pkg::nibble_exchange_to_acc: na = {m[3:0], m[7:4]};
      rsx_pkg::exclusive_or_to_acc, rsx_pkg::exclusive_or_imm_to_acc: na = a ^ s;
      rsx_pkg::exclusive_or_to_mem: nm = a ^ s;
      default: ;
    endcase
    if (op >= rsx_pkg::subtract_borrow_to_acc && op <= rsx_pkg::subtract_to_mem)
      nf = {(a[7] ^ s[7]) & (a[7] ^ d[7]), d[7:0] == 8'h00,
        ~h[4], ~d[8]};
    if (op >= rsx_pkg::exclusive_or_to_acc && op <= rsx_pkg::exclusive_or_to_mem)
      nf[2] = (a ^ s) == 8'h00;
    case (op)
      rsx_pkg::decrement_skip_zero_mem, rsx_pkg::decrement_skip_zero_to_acc: sk = m == 8'h01;
      rsx_pkg::increment_skip_zero_mem, rsx_pkg::increment_skip_zero_to_acc: sk = m == 8'hFF;
      rsx_pkg::skip_bit_set: sk = m[bi];
      rsx_pkg::skip_bit_clear: sk = ~m[bi];
      rsx_pkg::skip_if_zero_mem, rsx_pkg::copy_skip_if_zero: sk = m == 8'h00;
      default: sk = 1'b0;
    endcase
  endfunction

  task automatic op_case(input rsx_pkg::rsx_op_t op, input logic [2:0] bi,
      input logic [7:0] a, m, x, input logic [3:0] f);
    logic [7:0] na, nm;
    logic [3:0] nf;
    logic sk;
    int p0;
    model(op, bi, a, m, x, f, na, nm, nf, sk);
    xfer(1'b1, rsx_pkg::OFS_ACC, {24'h0, a});
    xfer(1'b1, rsx_pkg::OFS_MEM, {24'h0, m});
    xfer(1'b1, rsx_pkg::OFS_IMM, {24'h0, x});
    xfer(1'b1, rsx_pkg::OFS_FLAGS, {28'h0, f});
    p0 = pulses;
    run(op, bi, 1'b0);
    rdchk(rsx_pkg::OFS_ACC, {24'h0, na}, "acc");
    rdchk(rsx_pkg::OFS_MEM, {24'h0, nm}, "mem");
    rdchk(rsx_pkg::OFS_FLAGS, {28'h0, nf}, "flags");
    rdchk(rsx_pkg::OFS_STATUS, {29'h0, 1'b0, sk, 1'b0}, "status");
    chk(pulses - p0, {31'h0, sk}, "skip pulses");
    if (sk) chk(pulse_cyc - op_cyc, 32'h0000_0003, "skip delay");
  endtask

  task automatic tab_case(input rsx_pkg::rsx_op_t op, input logic hp, input logic [7:0] lo,
      input logic [3:0] page);
    xfer(1'b1, rsx_pkg::OFS_TPTR_LO, {24'h0, lo});
    xfer(1'b1, rsx_pkg::OFS_TPTR_HI, 32'h0000_0003);
    xfer(1'b1, rsx_pkg::OFS_FLAGS, 32'h0000_0005);
    run(op, 3'h0, hp);
    chk({20'h0, read_addr}, {20'h0, page, lo}, "table address");
    rdchk(rsx_pkg::OFS_MEM, {24'h0, lo ^ 8'hA5}, "table low byte");
    rdchk(rsx_pkg::OFS_TLATCH, {24'h0, page, lo[3:0]}, "table high byte");
    rdchk(rsx_pkg::OFS_FLAGS, 32'h0000_0005, "table flags");
  endtask

  initial begin
    apb_req = '0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(rsx_pkg::OFS_FLAGS, 32'h0000_0000, "flags after reset");
    op_case(rsx_pkg::rotate_left_to_acc, 0, 8'h11, 8'h81, 8'h00, 4'hF);
    op_case(rsx_pkg::rotate_left_thru_cy_mem, 0, 8'h00, 8'h81, 8'h00, 4'h0);
    op_case(rsx_pkg::rotate_left_thru_cy_mem, 0, 8'h00, 8'h40, 8'h00, 4'h1);
    op_case(rsx_pkg::rotate_left_thru_cy_to_acc, 0, 8'h00, 8'hC3, 8'h00, 4'h1);
    op_case(rsx_pkg::rotate_right_mem, 0, 8'h00, 8'h01, 8'h00, 4'hE);
    op_case(rsx_pkg::rotate_right_to_acc, 0, 8'h00, 8'h02, 8'h00, 4'hA);
    op_case(rsx_pkg::rotate_right_via_cy_mem, 0, 8'h00, 8'h01, 8'h00, 4'h0);
    op_case(rsx_pkg::rotate_right_via_cy_to_acc, 0, 8'h00, 8'h80, 8'h00, 4'h1);
    op_case(rsx_pkg::subtract_borrow_to_acc, 0, 8'h10, 8'h01, 8'h00, 4'h0);
    op_case(rsx_pkg::subtract_borrow_to_mem, 0, 8'h80, 8'h01, 8'h00, 4'h1);
    op_case(rsx_pkg::subtract_borrow_to_mem, 0, 8'h10, 8'h01, 8'h00, 4'h0);
    op_case(rsx_pkg::subtract_borrow_to_acc, 0, 8'h05, 8'h05, 8'h00, 4'h1);
    op_case(rsx_pkg::subtract_to_acc, 0, 8'h01, 8'h02, 8'h00, 4'h1);
    op_case(rsx_pkg::subtract_imm_to_acc, 0, 8'h20, 8'h00, 8'h20, 4'h0);
    op_case(rsx_pkg::subtract_to_mem, 0, 8'h7F, 8'hFF, 8'h00, 4'h0);
    op_case(rsx_pkg::decrement_skip_zero_mem, 0, 8'h00, 8'h01, 8'h00, 4'h5);
    op_case(rsx_pkg::decrement_skip_zero_to_acc, 0, 8'h33, 8'h00, 8'h00, 4'hA);
    op_case(rsx_pkg::increment_skip_zero_mem, 0, 8'h00, 8'hFF, 8'h00, 4'h3);
    op_case(rsx_pkg::increment_skip_zero_mem, 0, 8'h00, 8'h7F, 8'h00, 4'h3);
    op_case(rsx_pkg::increment_skip_zero_to_acc, 0, 8'h44, 8'hFF, 8'h00, 4'hC);
    op_case(rsx_pkg::skip_bit_set, 7, 8'h00, 8'h80, 8'h00, 4'h9);
    op_case(rsx_pkg::skip_bit_set, 0, 8'h00, 8'hFE, 8'h00, 4'h9);
    op_case(rsx_pkg::skip_bit_clear, 3, 8'h00, 8'hF7, 8'h00, 4'h6);
    op_case(rsx_pkg::skip_bit_clear, 3, 8'h00, 8'h08, 8'h00, 4'h6);
    op_case(rsx_pkg::skip_if_zero_mem, 0, 8'h00, 8'h00, 8'h00, 4'hF);
    op_case(rsx_pkg::skip_if_zero_mem, 0, 8'h00, 8'h5A, 8'h00, 4'hF);
    op_case(rsx_pkg::copy_skip_if_zero, 0, 8'h33, 8'h00, 8'h00, 4'h2);
    op_case(rsx_pkg::copy_skip_if_zero, 0, 8'h33, 8'h9C, 8'h00, 4'h2);
    op_case(rsx_pkg::set_all_mem, 0, 8'h00, 8'h12, 8'h00, 4'h7);
    op_case(rsx_pkg::set_bit_mem, 6, 8'h00, 8'h00, 8'h00, 4'h7);
    op_case(rsx_pkg::nibble_exchange_mem, 0, 8'h00, 8'h3C, 8'h00, 4'h4);
    op_case(rsx_pkg::nibble_exchange_to_acc, 0, 8'h00, 8'hA5, 8'h00, 4'h4);
    op_case(rsx_pkg::exclusive_or_to_acc, 0, 8'hF0, 8'h0F, 8'h00, 4'hF);
    op_case(rsx_pkg::exclusive_or_imm_to_acc, 0, 8'h55, 8'h00, 8'h55, 4'hB);
    op_case(rsx_pkg::exclusive_or_to_mem, 0, 8'hAA, 8'h0F, 8'h00, 4'h4);
    // Unused operation code: flagged, accumulator untouched
    run(5'h1D, 3'h0, 1'b0);
    rdchk(rsx_pkg::OFS_STATUS, 32'h0000_0004, "bad op flagged");
    rdchk(rsx_pkg::OFS_ACC, 32'h0000_00AA, "bad op no effect");
    xfer(1'b1, rsx_pkg::OFS_STATUS, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001, "status write refused");
    tab_case(rsx_pkg::program_word_read, 1'b1, 8'h6B, 4'h3);
    tab_case(rsx_pkg::program_word_read, 1'b0, 8'h2D, 4'h0);
    tab_case(rsx_pkg::last_page_word_read, 1'b1, 8'hC1, rsx_pkg::LAST_PAGE);
    xfer(1'b1, rsx_pkg::OFS_TLATCH, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001, "latch write refused");
    rdchk(rsx_pkg::OFS_TLATCH, {24'h0, rsx_pkg::LAST_PAGE, 4'h1}, "latch kept");
    xfer(1'b0, 8'h40, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
    close_out();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    $display("wrong value at %0t: run too long", $time);
    close_out();
  end
endmodule // rsx_exec_test
`default_nettype wire
